// ==== hw/conv_seq_defs.svh ====
`ifndef CONV_SEQ_DEFS_SVH
`define CONV_SEQ_DEFS_SVH
// register indices on the plain register port
`define REG_CTRL 4'h0
`define REG_SH_TIMING 4'h1
`define REG_SYNC 4'h2
`define REG_ASSIST 4'h3
`define REG_SAMPLE 4'h4
`define REG_SAR 4'h5
`define REG_MODE 4'h6
`define REG_STATUS 4'h7
`define REG_CLKGATE 4'h8
`define REG_CLKSTAT 4'h9
// ctrl fields
`define CTRL_START_BIT 0
`define CTRL_ABORT_BIT 1
// sh timing fields
`define SH_SAMPLE_LSB 0
`define SH_HOLD_LSB 8
// mode fields
`define MODE_SEL_LSB 0
`define MODE_SH_EN_BIT 2
`define MODE_ASSIST_EN_BIT 3
`define MODE_DIV1_BIT 4
`define MODE_AVG_LSB 8
`define SYNC_DIS0_BIT 16
`define SYNC_DIS1_BIT 17
// result processing latencies
`define LAT_SAR_DIV1 8'h06
`define LAT_SAR_OTHER 8'h07
`define LAT_DF_DIV1 8'h08
`define LAT_DF_OTHER 8'h09
`define BUS_LAT_DIV1 8'h02
`define BUS_LAT_OTHER 8'h06
// reset values
`define RST_SH_SAMPLE 8'h0d
`define RST_SH_HOLD 3'h4
`define RST_SYNC 11'h001
`define RST_ASSIST 4'h0
`define RST_SAMPLE 10'h00d
`define RST_SAR 6'h0f
`endif

// ==== hw/conv_seq_pkg.sv ====
package conv_seq_pkg;
  typedef enum logic [1:0] {
    mode_sar = 2'b00,
    mode_oversample = 2'b01,
    mode_hybrid = 2'b10
  } conv_mode_t;
  typedef enum logic [3:0] {
    st_idle = 4'b0000,
    st_sh_sample = 4'b0001,
    st_sh_hold = 4'b0010,
    st_assist = 4'b0011,
    st_sample = 4'b0100,
    st_sar = 4'b0101,
    st_result = 4'b0110,
    st_sh_back = 4'b0111,
    st_done = 4'b1000
  } phase_t;
endpackage

// ==== hw/phase_counter.sv ====
`timescale 1ns/100ps
`default_nettype none
module phase_counter #(
  parameter int W = 11
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic zero
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  initial begin
    if (W < 2) $error("phase_counter width too small");
  end
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  // a one-count phase ends one cycle after load
  // no load term here: load is built from zero, which would close a loop
  assign zero = (cnt_ff <= W'(1));
endmodule
`default_nettype wire

// ==== hw/conv_seq.sv ====
// Overview of operation
// - s&h sampling lasts sh_sample_states cycles
// - hold switching lasts sh_hold_switch_states cycles
// - hybrid only: back to sampling, sync minus one
// - assist adds zero or disconnect_assist_states cycles
// - sampling lasts sample_states cycles
// - successive approximation lasts sar_states cycles
// - sar, div1: 6/7 plus 2 bus
// - sar, other ratio: 7/8 plus 5-6
// - filtered, div1: 8/9 plus 2 bus
// - filtered, other ratio: 9/10 plus 5-6
// - averaging count from field, else one
// - clear gate enable, await running flag zero
//
// The implementer's own choices: the address map and the strobed register port.
`include "conv_seq_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module conv_seq #(
  parameter int CNT_W = 11,
  parameter int AVG_W = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic sh_sampling,
  output logic sh_holding,
  output logic adc_sampling,
  output logic adc_converting,
  output logic assist_active,
  output logic conv_busy,
  output logic conv_done,
  output logic conversion_clock_en
);
  initial begin
    if (CNT_W < 11) $error("CNT_W must cover the 11-bit sync field");
    if (AVG_W < 1 || AVG_W > 8) $error("AVG_W out of range");
  end

  // register state
  logic [7:0] sh_sample_ff, nxt_sh_sample;
  logic [2:0] sh_hold_ff, nxt_sh_hold;
  logic [10:0] sync_ff, nxt_sync;
  logic [3:0] assist_ff, nxt_assist;
  logic [9:0] sample_ff, nxt_sample;
  logic [5:0] sar_ff, nxt_sar;
  logic [1:0] mode_ff, nxt_mode;
  logic sh_en_ff, nxt_sh_en;
  logic assist_en_ff, nxt_assist_en;
  logic div1_ff, nxt_div1;
  logic [AVG_W-1:0] avg_ff, nxt_avg;
  logic [1:0] sync_dis_ff, nxt_sync_dis;
  logic gate_en_ff, nxt_gate_en;
  logic [31:0] rdata_ff, nxt_rdata;
  logic start_req;
  logic abort_req;

  // sequencer state
  conv_seq_pkg::phase_t phase_ff, nxt_phase;
  logic [AVG_W-1:0] rep_ff, nxt_rep;
  logic [CNT_W-1:0] load_val;
  logic load;
  logic cnt_zero;
  logic running_ff, nxt_running;
  logic [1:0] done_seen_ff, nxt_done_seen;
  logic sh_sampling_ff, sh_holding_ff, adc_sampling_ff, adc_converting_ff;
  logic assist_o_ff, busy_ff, done_ff;
  logic nxt_sh_sampling, nxt_sh_holding, nxt_adc_sampling, nxt_adc_converting;
  logic nxt_assist_o, nxt_busy, nxt_done;

  function automatic logic [CNT_W-1:0] widen(input logic [10:0] v);
    widen = CNT_W'(v);
  endfunction

  // result processing length in conversion-clock cycles, bus part folded in
  function automatic logic [7:0] result_len(input logic [1:0] m, input logic d1, input logic avg);
    logic [7:0] base;
    base = 8'h00;
    if (m == conv_seq_pkg::mode_sar) begin
      base = d1 ? `LAT_SAR_DIV1 : `LAT_SAR_OTHER;
    end else begin
      base = d1 ? `LAT_DF_DIV1 : `LAT_DF_OTHER;
    end
    // bus part taken at its longest so results never appear early
    result_len = base + 8'(avg) + (d1 ? `BUS_LAT_DIV1 : `BUS_LAT_OTHER);
  endfunction

  logic avg_used;
  assign avg_used = (avg_ff > AVG_W'(1));

  // register writes
  always_comb begin
    nxt_sh_sample = sh_sample_ff;
    nxt_sh_hold = sh_hold_ff;
    nxt_sync = sync_ff;
    nxt_assist = assist_ff;
    nxt_sample = sample_ff;
    nxt_sar = sar_ff;
    nxt_mode = mode_ff;
    nxt_sh_en = sh_en_ff;
    nxt_assist_en = assist_en_ff;
    nxt_div1 = div1_ff;
    nxt_avg = avg_ff;
    nxt_sync_dis = sync_dis_ff;
    nxt_gate_en = gate_en_ff;
    start_req = 1'b0;
    abort_req = 1'b0;
    if (wr) begin
      if (addr == `REG_CTRL) begin
        start_req = wdata[`CTRL_START_BIT];
        abort_req = wdata[`CTRL_ABORT_BIT];
      end else if (addr == `REG_SH_TIMING) begin
        nxt_sh_sample = wdata[`SH_SAMPLE_LSB +: 8];
        nxt_sh_hold = wdata[`SH_HOLD_LSB +: 3];
      end else if (addr == `REG_SYNC) begin
        nxt_sync = wdata[10:0];
      end else if (addr == `REG_ASSIST) begin
        nxt_assist = wdata[3:0];
      end else if (addr == `REG_SAMPLE) begin
        nxt_sample = wdata[9:0];
      end else if (addr == `REG_SAR) begin
        nxt_sar = wdata[5:0];
      end else if (addr == `REG_MODE) begin
        nxt_mode = wdata[`MODE_SEL_LSB +: 2];
        nxt_sh_en = wdata[`MODE_SH_EN_BIT];
        nxt_assist_en = wdata[`MODE_ASSIST_EN_BIT];
        nxt_div1 = wdata[`MODE_DIV1_BIT];
        nxt_avg = wdata[`MODE_AVG_LSB +: AVG_W];
        nxt_sync_dis = {wdata[`SYNC_DIS1_BIT], wdata[`SYNC_DIS0_BIT]};
      end else if (addr == `REG_CLKGATE) begin
        nxt_gate_en = wdata[0];
      end
    end
  end

  // register reads, unmapped indices read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd) begin
      if (addr == `REG_SH_TIMING) begin
        nxt_rdata = {21'h000000, sh_hold_ff, sh_sample_ff};
      end else if (addr == `REG_SYNC) begin
        nxt_rdata = {21'h000000, sync_ff};
      end else if (addr == `REG_ASSIST) begin
        nxt_rdata = {28'h0000000, assist_ff};
      end else if (addr == `REG_SAMPLE) begin
        nxt_rdata = {22'h000000, sample_ff};
      end else if (addr == `REG_SAR) begin
        nxt_rdata = {26'h0000000, sar_ff};
      end else if (addr == `REG_MODE) begin
        nxt_rdata[`MODE_SEL_LSB +: 2] = mode_ff;
        nxt_rdata[`MODE_SH_EN_BIT] = sh_en_ff;
        nxt_rdata[`MODE_ASSIST_EN_BIT] = assist_en_ff;
        nxt_rdata[`MODE_DIV1_BIT] = div1_ff;
        nxt_rdata[`MODE_AVG_LSB +: AVG_W] = avg_ff;
        nxt_rdata[`SYNC_DIS1_BIT] = sync_dis_ff[1];
        nxt_rdata[`SYNC_DIS0_BIT] = sync_dis_ff[0];
      end else if (addr == `REG_STATUS) begin
        nxt_rdata = {24'h000000, busy_ff, done_ff, 2'b00, 4'(phase_ff)};
      end else if (addr == `REG_CLKGATE) begin
        nxt_rdata = {31'h00000000, gate_en_ff};
      end else if (addr == `REG_CLKSTAT) begin
        nxt_rdata = {31'h00000000, running_ff};
      end
    end
  end

  // phase sequencing
  always_comb begin
    nxt_phase = phase_ff;
    nxt_rep = rep_ff;
    load = 1'b0;
    load_val = '0;
    case (phase_ff)
      conv_seq_pkg::st_idle: begin
        // no start while the conversion clock is gated off
        if (start_req && running_ff) begin
          nxt_rep = (avg_ff == '0) ? AVG_W'(1) : avg_ff;
          load = 1'b1;
          if (sh_en_ff) begin
            nxt_phase = conv_seq_pkg::st_sh_sample;
            load_val = widen({3'h0, sh_sample_ff});
          end else if (assist_en_ff) begin
            nxt_phase = conv_seq_pkg::st_assist;
            load_val = widen({7'h00, assist_ff});
          end else begin
            nxt_phase = conv_seq_pkg::st_sample;
            load_val = widen({1'b0, sample_ff});
          end
        end
      end
      conv_seq_pkg::st_sh_sample: begin
        if (cnt_zero) begin
          load = 1'b1;
          nxt_phase = conv_seq_pkg::st_sh_hold;
          load_val = widen({8'h00, sh_hold_ff});
        end
      end
      conv_seq_pkg::st_sh_hold, conv_seq_pkg::st_sh_back: begin
        if (cnt_zero) begin
          load = 1'b1;
          // assist disabled adds nothing
          if (assist_en_ff) begin
            nxt_phase = conv_seq_pkg::st_assist;
            load_val = widen({7'h00, assist_ff});
          end else begin
            nxt_phase = conv_seq_pkg::st_sample;
            load_val = widen({1'b0, sample_ff});
          end
        end
      end
      conv_seq_pkg::st_assist: begin
        if (cnt_zero) begin
          load = 1'b1;
          nxt_phase = conv_seq_pkg::st_sample;
          load_val = widen({1'b0, sample_ff});
        end
      end
      conv_seq_pkg::st_sample: begin
        if (cnt_zero) begin
          load = 1'b1;
          nxt_phase = conv_seq_pkg::st_sar;
          load_val = widen({5'h00, sar_ff});
        end
      end
      conv_seq_pkg::st_sar: begin
        if (cnt_zero) begin
          load = 1'b1;
          if (rep_ff > AVG_W'(1)) begin
            nxt_rep = rep_ff - AVG_W'(1);
            if (mode_ff == conv_seq_pkg::mode_hybrid && sh_en_ff) begin
              nxt_phase = conv_seq_pkg::st_sh_back;
              load_val = widen(sync_ff - 11'h001);
            end else if (assist_en_ff) begin
              nxt_phase = conv_seq_pkg::st_assist;
              load_val = widen({7'h00, assist_ff});
            end else begin
              nxt_phase = conv_seq_pkg::st_sample;
              load_val = widen({1'b0, sample_ff});
            end
          end else begin
            nxt_phase = conv_seq_pkg::st_result;
            load_val = widen({3'h0, result_len(mode_ff, div1_ff, avg_used)});
          end
        end
      end
      conv_seq_pkg::st_result: begin
        if (cnt_zero) begin
          nxt_phase = conv_seq_pkg::st_done;
        end
      end
      conv_seq_pkg::st_done: begin
        nxt_phase = conv_seq_pkg::st_idle;
      end
      default: begin
        nxt_phase = conv_seq_pkg::st_idle;
      end
    endcase
    if (abort_req) begin
      nxt_phase = conv_seq_pkg::st_idle;
    end
  end

  // gate status follows enable after three cycles, like a clock stop handshake
  always_comb begin
    nxt_done_seen = {done_seen_ff[0], gate_en_ff};
    nxt_running = done_seen_ff[1];
    nxt_sh_sampling = (nxt_phase == conv_seq_pkg::st_sh_sample) || (nxt_phase == conv_seq_pkg::st_sh_back);
    nxt_sh_holding = (nxt_phase == conv_seq_pkg::st_sh_hold);
    nxt_adc_sampling = (nxt_phase == conv_seq_pkg::st_sample);
    nxt_adc_converting = (nxt_phase == conv_seq_pkg::st_sar);
    nxt_assist_o = (nxt_phase == conv_seq_pkg::st_assist);
    nxt_busy = (nxt_phase != conv_seq_pkg::st_idle) && (nxt_phase != conv_seq_pkg::st_done);
    nxt_done = (nxt_phase == conv_seq_pkg::st_done);
  end

  phase_counter #(.W(CNT_W)) u_cnt (
    .clk(clk),
    .rstn(rstn),
    .load(load),
    .load_val(load_val),
    .zero(cnt_zero)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_sample_ff <= `RST_SH_SAMPLE;
      sh_hold_ff <= `RST_SH_HOLD;
      sync_ff <= `RST_SYNC;
      assist_ff <= `RST_ASSIST;
      sample_ff <= `RST_SAMPLE;
      sar_ff <= `RST_SAR;
      mode_ff <= 2'h0;
      sh_en_ff <= 1'b0;
      assist_en_ff <= 1'b0;
      div1_ff <= 1'b0;
      avg_ff <= '0;
      sync_dis_ff <= 2'h3;
      gate_en_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      phase_ff <= conv_seq_pkg::st_idle;
      rep_ff <= '0;
      running_ff <= 1'b0;
      done_seen_ff <= 2'h0;
      sh_sampling_ff <= 1'b0;
      sh_holding_ff <= 1'b0;
      adc_sampling_ff <= 1'b0;
      adc_converting_ff <= 1'b0;
      assist_o_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      sh_sample_ff <= nxt_sh_sample;
      sh_hold_ff <= nxt_sh_hold;
      sync_ff <= nxt_sync;
      assist_ff <= nxt_assist;
      sample_ff <= nxt_sample;
      sar_ff <= nxt_sar;
      mode_ff <= nxt_mode;
      sh_en_ff <= nxt_sh_en;
      assist_en_ff <= nxt_assist_en;
      div1_ff <= nxt_div1;
      avg_ff <= nxt_avg;
      sync_dis_ff <= nxt_sync_dis;
      gate_en_ff <= nxt_gate_en;
      rdata_ff <= nxt_rdata;
      phase_ff <= nxt_phase;
      rep_ff <= nxt_rep;
      running_ff <= nxt_running;
      done_seen_ff <= nxt_done_seen;
      sh_sampling_ff <= nxt_sh_sampling;
      sh_holding_ff <= nxt_sh_holding;
      adc_sampling_ff <= nxt_adc_sampling;
      adc_converting_ff <= nxt_adc_converting;
      assist_o_ff <= nxt_assist_o;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign rdata = rdata_ff;
  assign sh_sampling = sh_sampling_ff;
  assign sh_holding = sh_holding_ff;
  assign adc_sampling = adc_sampling_ff;
  assign adc_converting = adc_converting_ff;
  assign assist_active = assist_o_ff;
  assign conv_busy = busy_ff;
  assign conv_done = done_ff;
  assign conversion_clock_en = running_ff;
endmodule
`default_nettype wire

// ==== tb/conv_seq_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "conv_seq_defs.svh"
module conv_seq_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic sh_sampling,
  input wire logic sh_holding,
  input wire logic adc_sampling,
  input wire logic adc_converting,
  input wire logic assist_active,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic conversion_clock_en
);
  logic [10:0] sh_ff, nxt_sh;
  logic [9:0] smp_ff, nxt_smp;
  logic [5:0] sar_ff, nxt_sar;
  logic [3:0] as_ff, nxt_as;
  logic [17:0] mode_ff, nxt_mode;
  logic gate_ff, nxt_gate;
  int run_ff [5];
  int nxt_run [5];
  int since_ff, nxt_since, lat_exp;
  logic [4:0] flags;
  function automatic int m1(input int v);
    return (v == 0) ? 1 : v;
  endfunction
  assign flags = {adc_converting, adc_sampling, assist_active, sh_holding, sh_sampling};
  // shadow of the timing fields, so each length check needs no bus reads
  always_comb begin
    nxt_sh = sh_ff;
    nxt_smp = smp_ff;
    nxt_sar = sar_ff;
    nxt_as = as_ff;
    nxt_mode = mode_ff;
    nxt_gate = gate_ff;
    if (wr) begin
      case (addr)
        `REG_SH_TIMING: nxt_sh = wdata[10:0];
        `REG_ASSIST: nxt_as = wdata[3:0];
        `REG_SAMPLE: nxt_smp = wdata[9:0];
        `REG_SAR: nxt_sar = wdata[5:0];
        `REG_MODE: nxt_mode = wdata[17:0];
        `REG_CLKGATE: nxt_gate = wdata[0];
        default: ;
      endcase
    end
    for (int i = 0; i < 5; i++) nxt_run[i] = flags[i] ? run_ff[i] + 1 : 0;
    nxt_since = adc_converting ? 0 : since_ff + 1;
    // bus part counted in conversion clocks, 6 taken for the 5 to 6 case
    lat_exp = ((mode_ff[1:0] == 2'b00) ? 6 : 8) + (mode_ff[4] ? 2 : 7) + ((mode_ff[11:8] > 4'h1) ? 1 : 0);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_ff <= {`RST_SH_HOLD, `RST_SH_SAMPLE};
      smp_ff <= `RST_SAMPLE;
      sar_ff <= `RST_SAR;
      as_ff <= `RST_ASSIST;
      mode_ff <= 18'h30000;
      gate_ff <= 1'b0;
      run_ff <= '{default: 0};
      since_ff <= 0;
    end else begin
      sh_ff <= nxt_sh;
      smp_ff <= nxt_smp;
      sar_ff <= nxt_sar;
      as_ff <= nxt_as;
      mode_ff <= nxt_mode;
      gate_ff <= nxt_gate;
      run_ff <= nxt_run;
      since_ff <= nxt_since;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_phase_excl: assert property ($onehot0(flags))
    else $error("phase flags overlap");
  a_sh_unused: assert property ((sh_sampling || sh_holding) |-> mode_ff[2])
    else $error("sample and hold active while disabled");
  a_sh_sample_len: assert property ($fell(sh_sampling) && mode_ff[1:0] != 2'b10 |-> run_ff[0] == m1(sh_ff[7:0]))
    else $error("sample and hold sampling length wrong");
  a_hold_len: assert property ($fell(sh_holding) |-> run_ff[1] == m1(sh_ff[10:8]))
    else $error("hold switching length wrong");
  a_back_hybrid: assert property ($rose(sh_sampling) && $past(adc_converting) |-> mode_ff[1:0] == 2'b10)
    else $error("back switch outside hybrid mode");
  a_assist_off: assert property (assist_active |-> mode_ff[3])
    else $error("assist while disabled");
  a_assist_len: assert property ($fell(assist_active) |-> run_ff[2] == m1(as_ff))
    else $error("assist length wrong");
  a_sample_len: assert property ($fell(adc_sampling) |-> run_ff[3] == m1(smp_ff))
    else $error("sampling length wrong");
  a_sar_len: assert property ($fell(adc_converting) |-> run_ff[4] == m1(sar_ff))
    else $error("approximation length wrong");
  a_result_lat: assert property (conv_done |-> since_ff >= lat_exp - 1 && since_ff <= lat_exp + 1)
    else $error("result latency wrong");
  a_gate_follow: assert property (wr && addr == `REG_CLKGATE |-> ##[2:4] conversion_clock_en == gate_ff)
    else $error("running flag does not follow gate");
  a_start_gated: assert property ($rose(conv_busy) |-> $past(conversion_clock_en))
    else $error("conversion started with clock stopped");
  c_assist: cover property ($fell(assist_active));
  c_hybrid_done: cover property (conv_done && mode_ff[1:0] == 2'b10);
  c_gate_off: cover property ($fell(conversion_clock_en));
endmodule
bind conv_seq conv_seq_chk chk (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .sh_sampling(sh_sampling),
  .sh_holding(sh_holding), .adc_sampling(adc_sampling), .adc_converting(adc_converting),
  .assist_active(assist_active), .conv_busy(conv_busy), .conv_done(conv_done),
  .conversion_clock_en(conversion_clock_en)
);
`default_nettype wire

// ==== tb/analog_side.sv ====
`timescale 1ns/100ps
`default_nettype none
// far side: channels and hold circuits tally how long each phase drives them
module analog_side (
  input wire logic clk,
  input wire logic clr,
  input wire logic [4:0] flags,
  output int tot [5],
  output int runs,
  output int lat
);
  logic conv_q;
  always @(posedge clk) begin
    if (clr) begin
      tot <= '{default: 0};
      runs <= 0;
    end else begin
      for (int i = 0; i < 5; i++) tot[i] <= tot[i] + int'(flags[i]);
      if (flags[4] && !conv_q) runs <= runs + 1;
    end
    conv_q <= flags[4];
    lat <= flags[4] ? 0 : lat + 1;
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "conv_seq_defs.svh"
module testbench;
  logic clk, rstn, wr, rd, clr, she, ase, d1;
  logic [1:0] md;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, got, r;
  logic sh_sampling, sh_holding, adc_sampling, adc_converting, assist_active, conv_busy, conv_done, conversion_clock_en;
  int tot [5];
  int runs, lat, fails, comparisons, seed, avg;
  logic [3:0] ra [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hf};
  logic [31:0] rv [9] = '{32'h40d, 32'h1, 32'h0, 32'hd, 32'hf, 32'h30000, 32'h0, 32'h0, 32'h0};
  conv_seq dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sh_sampling(sh_sampling), .sh_holding(sh_holding), .adc_sampling(adc_sampling),
    .adc_converting(adc_converting), .assist_active(assist_active), .conv_busy(conv_busy),
    .conv_done(conv_done), .conversion_clock_en(conversion_clock_en)
  );
  analog_side far (
    .clk(clk), .clr(clr), .flags({adc_converting, adc_sampling, assist_active, sh_holding, sh_sampling}),
    .tot(tot), .runs(runs), .lat(lat)
  );
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic int m1(input int v);
    return (v == 0) ? 1 : v;
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // bounded wait on the running flag or the done pulse
  task automatic wait_on(input bit on_flag);
    int i;
    for (i = 0; i < 20000; i++) begin
      if ((on_flag ? conversion_clock_en : conv_done) === 1'b1) break;
      @(posedge clk);
    end
    if (i == 20000) begin
      fails++;
      $display("[FAIL] wait expected 1 seen timeout");
      complete_run();
    end
  endtask
  task automatic run_conv(input int shs, shh, syn, asst, smp, sar);
    int a, e_lat;
    a = m1(avg);
    wr_reg(`REG_SH_TIMING, {21'h0, shh[2:0], shs[7:0]});
    wr_reg(`REG_SYNC, syn);
    wr_reg(`REG_ASSIST, asst);
    wr_reg(`REG_SAMPLE, smp);
    wr_reg(`REG_SAR, sar);
    wr_reg(`REG_MODE, {14'h0, 2'b11, 4'h0, avg[3:0], 3'h0, d1, ase, she, md});
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wr_reg(`REG_CTRL, 32'h1);
    wait_on(1'b0);
    // hold circuit samples and holds once per scan, hybrid repeats only switch it back
    check("sh_sample", she ? m1(shs) + ((md == 2'b10) ? (a - 1) * m1(syn - 1) : 0) : 0, tot[0]);
    check("sh_hold", she ? m1(shh) : 0, tot[1]);
    check("assist", ase ? a * m1(asst) : 0, tot[2]);
    check("sample", a * m1(smp), tot[3]);
    check("sar", a * m1(sar), tot[4]);
    check("averages", a, runs);
    e_lat = ((md == 2'b00) ? 6 : 8) + (d1 ? 2 : 7) + ((avg > 1) ? 1 : 0);
    check("latency", 1, lat >= e_lat - 1 && lat <= e_lat + 1);
    $display("conversion mode %0d ratio1 %0d avg %0d done", md, d1, avg);
  endtask
  initial begin
    seed = 37;
    fails = 0;
    comparisons = 0;
    rstn = 1'b0;
    {wr, rd, clr, addr, wdata} = '0;
    {md, she, ase, d1, avg} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd_reg(ra[i], got);
      check("reset value", rv[i], got);
    end
    wr_reg(4'hf, 32'hffffffff);
    rd_reg(4'hf, got);
    check("unmapped", 32'h0, got);
    wr_reg(`REG_CTRL, 32'h1);
    repeat (8) @(posedge clk);
    check("busy while gated", 32'h0, conv_busy);
    // no timer clock source here, so no module stop to lift first
    wr_reg(`REG_CLKGATE, 32'h1);
    wait_on(1'b1);
    rd_reg(`REG_CLKSTAT, got);
    check("running flag", 32'h1, got);
    $display("register and gate test done");
    {md, she, ase, d1, avg} = {2'b00, 3'b111, 32'd1};
    run_conv(255, 7, 2, 15, 1023, 63);
    {ase, d1, avg} = '0;
    run_conv(0, 0, 2, 0, 0, 0);
    // sync stays disabled, so the sync period is written only for hybrid use
    for (int k = 0; k < 12; k++) begin
      r = $random(seed);
      md = 2'(k % 3);
      d1 = ((k / 3) % 2) == 1;
      she = r[0];
      ase = r[1];
      // outside hybrid the hold circuit runs once per scan, so no averaging with it
      avg = (md != 2'b10 && she) ? 1 : int'(r[5:4]);
      run_conv($random(seed) & 255, $random(seed) & 7, 2 + ($random(seed) & 63), $random(seed) & 15,
        $random(seed) & 255, $random(seed) & 63);
    end
    // abort lands in the long result phase, so no phase flag is cut short
    wr_reg(`REG_MODE, 32'h30001);
    wr_reg(`REG_SAMPLE, 32'h0);
    wr_reg(`REG_SAR, 32'h0);
    wr_reg(`REG_CTRL, 32'h1);
    rd_reg(`REG_STATUS, got);
    check("status", 32'h85, got);
    wr_reg(`REG_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    check("aborted", 32'h0, conv_busy);
    $display("status and abort test done");
    wr_reg(`REG_CLKGATE, 32'h0);
    repeat (5) @(posedge clk);
    check("flag stopped", 32'h0, conversion_clock_en);
    complete_run();
  end
endmodule
`default_nettype wire
